// ==== src/sw_pos_pkg.sv ====
package sw_pos_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_WIRING   = 8'h04;
  localparam logic [7:0] OFS_T_CLOSE  = 8'h08;
  localparam logic [7:0] OFS_T_OPEN   = 8'h0C;
  localparam logic [7:0] OFS_T_SETTLE = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;

  // field positions
  localparam int CMD_CLOSE_BIT  = 0;
  localparam int CMD_OPEN_BIT   = 1;
  localparam int WIRE_CL_BIT    = 0;
  localparam int WIRE_OP_BIT    = 1;
  localparam int ST_CODE_LSB    = 0;
  localparam int ST_FLAG_LSB    = 2;
  localparam int ST_ONE_BIT     = 6;
  localparam int ST_DRV_CL_BIT  = 7;
  localparam int ST_DRV_OP_BIT  = 8;
  localparam int EV_CLOSED_BIT  = 0;
  localparam int EV_OPEN_BIT    = 1;
  localparam int EV_FAULT_BIT   = 2;
  localparam int EV_W           = 3;

  // position codes
  localparam logic [1:0] POS_TRANSIT = 2'h0;
  localparam logic [1:0] POS_OPEN    = 2'h1;
  localparam logic [1:0] POS_CLOSED  = 2'h2;
  localparam logic [1:0] POS_FAULT   = 2'h3;

  // reset values
  localparam logic [31:0] T_CLOSE_RST  = 32'h0000_1000;
  localparam logic [31:0] T_OPEN_RST   = 32'h0000_1000;
  localparam logic [31:0] T_SETTLE_RST = 32'h0000_0000;
  localparam logic [1:0]  WIRING_RST   = 2'h3;

  // motion states
  typedef enum logic [1:0] {ST_IDLE, ST_CLOSING, ST_OPENING, ST_SETTLE} motion_e;

endpackage : sw_pos_pkg

// ==== src/travel_timer_if.sv ====
`timescale 1ns/1ps
// load, start and done of one travel timer
interface travel_timer_if #(parameter int TIME_W = 32);
  logic              start;   // load and run
  logic              stop;    // abandon the count
  logic [TIME_W-1:0] load;    // cycles to run
  logic              busy;    // count running
  logic              expired; // last cycle of the count
  modport ctrl  (output start, stop, load, input busy, expired);
  modport timer (input start, stop, load, output busy, expired);
endinterface : travel_timer_if

// ==== src/travel_timer.sv ====
`timescale 1ns/1ps
module travel_timer #(
  parameter int TIME_W = 32
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  travel_timer_if.timer   tmr
);

  logic [TIME_W-1:0] cnt;      // cycles left
  logic [TIME_W-1:0] next_cnt; // next count

  // a zero load still runs one cycle so a drive never vanishes
  always_comb
  begin
    next_cnt = cnt;
    if (tmr.stop)
      next_cnt = '0;
    else if (tmr.start)
      next_cnt = (tmr.load == '0) ? TIME_W'(1) : tmr.load;
    else if (cnt != '0)
      next_cnt = cnt - TIME_W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  assign tmr.busy    = (cnt != '0);
  // expiry must not look at start or stop: the controller derives start from it
  assign tmr.expired = (cnt == TIME_W'(1));

endmodule : travel_timer

// ==== src/irq_status.sv ====
`timescale 1ns/1ps
module irq_status #(
  parameter int EV_W = 3
) (
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  // events and software side
  input  wire logic [EV_W-1:0] ev_i,
  input  wire logic [EV_W-1:0] mask_i,
  input  wire logic            clr_i,
  output logic      [EV_W-1:0] stat_o,
  output logic                 irq_o
);

  logic [EV_W-1:0] next_stat; // sticky bits after this cycle

  // a read clears, but an event in the same cycle survives it
  always_comb
  begin
    next_stat = (clr_i ? '0 : stat_o) | ev_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_o <= '0;
      irq_o  <= 1'b0;
    end
    else
    begin
      stat_o <= next_stat;
      irq_o  <= |(next_stat & mask_i);
    end
  end

endmodule : irq_status

// ==== src/sw_pos_supervisor.sv ====
`timescale 1ns/1ps
// How it works
// - drive lasts travel time, ends at arrival
// - contacts sampled always, judged with timers
// - code 0 transit, 1 open, 2 closed, 3 fault
// - close runs timer, arrival closed, expiry fault; after a settle two contacts decide
// - open runs timer, arrival open, expiry fault; after a settle two contacts decide
// - two contacts: table gives flags and code
// - two contacts reveal intermediate and disturbed
// - one contact still times command to arrival
// - flag reports single contact wiring
// - single contact supervises only its direction
// - optional settle after expiry shows transit
// - no contact wired forces code three
module sw_pos_supervisor #(
  parameter int TIME_W = 32
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // auxiliary contacts
  input  wire logic        aux_closed_i,
  input  wire logic        aux_open_i,
  // drive coils
  output logic             drive_close_o,
  output logic             drive_open_o,
  // validated position
  output logic      [1:0]  pos_code_o,
  output logic             pos_closed_o,
  output logic             pos_open_o,
  output logic             pos_transit_o,
  output logic             pos_fault_o,
  output logic             one_contact_flag_o,
  // interrupt
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  // merge write data into a register under the byte enables
  function automatic logic [31:0] sel_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    return r;
  endfunction : sel_merge

  ////////////////////////////////////////////////////////////////////
  // bus decode

  logic        bus_req;  // access pending and not yet answered
  logic        wr_acc;   // write taken this edge
  logic        rd_acc;   // read taken this edge
  logic [31:0] rd_data;  // read mux

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_acc  = bus_req && wb_we_i;
  assign rd_acc  = bus_req && !wb_we_i;

  ////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [TIME_W-1:0]           t_close;      // closing travel cycles
  logic [TIME_W-1:0]           t_open;       // opening travel cycles
  logic [TIME_W-1:0]           t_settle;     // settle cycles, zero skips
  logic [1:0]                  wiring;       // which contacts exist
  logic [sw_pos_pkg::EV_W-1:0] irq_mask;     // interrupt enables
  logic [TIME_W-1:0]           next_t_close;
  logic [TIME_W-1:0]           next_t_open;
  logic [TIME_W-1:0]           next_t_settle;
  logic [1:0]                  next_wiring;
  logic [sw_pos_pkg::EV_W-1:0] next_irq_mask;

  // software writes, byte lanes honoured
  always_comb
  begin
    next_t_close  = t_close;
    next_t_open   = t_open;
    next_t_settle = t_settle;
    next_wiring   = wiring;
    next_irq_mask = irq_mask;
    if (wr_acc)
    begin
      if (wb_adr_i == sw_pos_pkg::OFS_T_CLOSE)
        next_t_close = TIME_W'(sel_merge(32'(t_close), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == sw_pos_pkg::OFS_T_OPEN)
        next_t_open = TIME_W'(sel_merge(32'(t_open), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == sw_pos_pkg::OFS_T_SETTLE)
        next_t_settle = TIME_W'(sel_merge(32'(t_settle), wb_dat_i, wb_sel_i));
      else if (wb_adr_i == sw_pos_pkg::OFS_WIRING && wb_sel_i[0])
        next_wiring = wb_dat_i[1:0];
      else if (wb_adr_i == sw_pos_pkg::OFS_IRQ_MASK && wb_sel_i[0])
        next_irq_mask = wb_dat_i[sw_pos_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      t_close  <= TIME_W'(sw_pos_pkg::T_CLOSE_RST);
      t_open   <= TIME_W'(sw_pos_pkg::T_OPEN_RST);
      t_settle <= TIME_W'(sw_pos_pkg::T_SETTLE_RST);
      wiring   <= sw_pos_pkg::WIRING_RST;
      irq_mask <= '0;
    end
    else
    begin
      t_close  <= next_t_close;
      t_open   <= next_t_open;
      t_settle <= next_t_settle;
      wiring   <= next_wiring;
      irq_mask <= next_irq_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // contact evaluation

  logic wired_cl;  // closed contact present
  logic wired_op;  // open contact present
  logic both;      // full two-contact wiring
  logic one_wire;  // single contact wiring
  logic at_closed; // contacts report closed
  logic at_open;   // contacts report open
  logic cmd_close; // close command written
  logic cmd_open;  // open command written

  assign wired_cl = wiring[sw_pos_pkg::WIRE_CL_BIT];
  assign wired_op = wiring[sw_pos_pkg::WIRE_OP_BIT];
  assign both     = wired_cl && wired_op;
  assign one_wire = wired_cl ^ wired_op;

  always_comb
  begin
    if (both)
    begin
      at_closed = aux_closed_i && !aux_open_i;
      at_open   = !aux_closed_i && aux_open_i;
    end
    else if (wired_cl)
    begin
      at_closed = aux_closed_i;
      at_open   = !aux_closed_i;
    end
    else if (wired_op)
    begin
      at_closed = !aux_open_i;
      at_open   = aux_open_i;
    end
    else
    begin
      at_closed = 1'b0;
      at_open   = 1'b0;
    end
  end

  assign cmd_close = wr_acc && wb_adr_i == sw_pos_pkg::OFS_CMD && wb_sel_i[0]
                     && wb_dat_i[sw_pos_pkg::CMD_CLOSE_BIT];
  assign cmd_open  = wr_acc && wb_adr_i == sw_pos_pkg::OFS_CMD && wb_sel_i[0]
                     && wb_dat_i[sw_pos_pkg::CMD_OPEN_BIT];

  ////////////////////////////////////////////////////////////////////
  // motion state machine

  travel_timer_if #(.TIME_W(TIME_W)) tif ();

  travel_timer #(.TIME_W(TIME_W)) u_timer (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tmr   (tif.timer)
  );

  sw_pos_pkg::motion_e state;         // current motion
  sw_pos_pkg::motion_e next_state;
  logic                sup;           // this travel is supervised
  logic                next_sup;
  logic                dir_cl;        // target is closed
  logic                next_dir_cl;
  logic                hold;          // supervised travel expired without arrival
  logic                next_hold;
  logic                target_hit;    // target end position seen

  assign target_hit = dir_cl ? at_closed : at_open;

  // commands only from idle; open wins a tie since it is the safe move
  always_comb
  begin
    next_state  = state;
    next_sup    = sup;
    next_dir_cl = dir_cl;
    next_hold   = hold && !target_hit;
    tif.start   = 1'b0;
    tif.stop    = 1'b0;
    tif.load    = t_open;
    case (state)
      sw_pos_pkg::ST_IDLE:
      begin
        if (cmd_open)
        begin
          next_state  = sw_pos_pkg::ST_OPENING;
          next_dir_cl = 1'b0;
          next_sup    = wired_op;
          next_hold   = 1'b0;
          tif.start   = 1'b1;
          tif.load    = t_open;
        end
        else if (cmd_close)
        begin
          next_state  = sw_pos_pkg::ST_CLOSING;
          next_dir_cl = 1'b1;
          next_sup    = wired_cl;
          next_hold   = 1'b0;
          tif.start   = 1'b1;
          tif.load    = t_close;
        end
      end
      sw_pos_pkg::ST_CLOSING, sw_pos_pkg::ST_OPENING:
      begin
        if (target_hit)
        begin
          next_state = sw_pos_pkg::ST_IDLE;
          tif.stop   = 1'b1;
        end
        else if (tif.expired)
        begin
          if (sup && t_settle != '0)
          begin
            next_state = sw_pos_pkg::ST_SETTLE;
            tif.start  = 1'b1;
            tif.load   = t_settle;
          end
          else
          begin
            next_state = sw_pos_pkg::ST_IDLE;
            next_hold  = sup;
          end
        end
      end
      sw_pos_pkg::ST_SETTLE:
      begin
        if (tif.expired)
        begin
          next_state = sw_pos_pkg::ST_IDLE;
          next_hold  = one_wire && !target_hit;
        end
      end
      default:
        next_state = sw_pos_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state  <= sw_pos_pkg::ST_IDLE;
      sup    <= 1'b0;
      dir_cl <= 1'b0;
      hold   <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      sup    <= next_sup;
      dir_cl <= next_dir_cl;
      hold   <= next_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // position code and flags

  logic       transit_now;  // supervised travel or settle running
  logic [1:0] next_code;
  logic       next_drv_cl;
  logic       next_drv_op;

  assign transit_now = state == sw_pos_pkg::ST_SETTLE
                       || (sup && !target_hit && (state == sw_pos_pkg::ST_CLOSING
                                                  || state == sw_pos_pkg::ST_OPENING));

  always_comb
  begin
    if (!wired_cl && !wired_op)
      next_code = sw_pos_pkg::POS_FAULT;
    // supervised travel or settle shows in transit
    else if (transit_now)
      next_code = sw_pos_pkg::POS_TRANSIT;
    // expiry without arrival is a fault
    else if (hold)
      next_code = sw_pos_pkg::POS_FAULT;
    else if (at_closed)
      next_code = sw_pos_pkg::POS_CLOSED;
    else if (at_open)
      next_code = sw_pos_pkg::POS_OPEN;
    // equal contacts at rest are disturbed
    else
      next_code = sw_pos_pkg::POS_FAULT;
  end

  // drive follows the motion state so it ends with the travel
  assign next_drv_cl = next_state == sw_pos_pkg::ST_CLOSING;
  assign next_drv_op = next_state == sw_pos_pkg::ST_OPENING;

  // flags decoded from one code, so one-hot
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_code_o         <= sw_pos_pkg::POS_FAULT;
      pos_closed_o       <= 1'b0;
      pos_open_o         <= 1'b0;
      pos_transit_o      <= 1'b0;
      pos_fault_o        <= 1'b1;
      one_contact_flag_o <= 1'b0;
      drive_close_o      <= 1'b0;
      drive_open_o       <= 1'b0;
    end
    else
    begin
      pos_code_o         <= next_code;
      pos_closed_o       <= next_code == sw_pos_pkg::POS_CLOSED;
      pos_open_o         <= next_code == sw_pos_pkg::POS_OPEN;
      pos_transit_o      <= next_code == sw_pos_pkg::POS_TRANSIT;
      pos_fault_o        <= next_code == sw_pos_pkg::POS_FAULT;
      one_contact_flag_o <= one_wire;
      drive_close_o      <= next_drv_cl;
      drive_open_o       <= next_drv_op;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupts and read back

  logic [sw_pos_pkg::EV_W-1:0] events;   // code changes into an end state
  logic [sw_pos_pkg::EV_W-1:0] irq_stat; // sticky status

  always_comb
  begin
    events = '0;
    events[sw_pos_pkg::EV_CLOSED_BIT] = next_code == sw_pos_pkg::POS_CLOSED
                                        && pos_code_o != sw_pos_pkg::POS_CLOSED;
    events[sw_pos_pkg::EV_OPEN_BIT]   = next_code == sw_pos_pkg::POS_OPEN
                                        && pos_code_o != sw_pos_pkg::POS_OPEN;
    events[sw_pos_pkg::EV_FAULT_BIT]  = next_code == sw_pos_pkg::POS_FAULT
                                        && pos_code_o != sw_pos_pkg::POS_FAULT;
  end

  irq_status #(.EV_W(sw_pos_pkg::EV_W)) u_irq (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ev_i   (events),
    .mask_i (irq_mask),
    .clr_i  (rd_acc && wb_adr_i == sw_pos_pkg::OFS_IRQ_STAT),
    .stat_o (irq_stat),
    .irq_o  (irq_o)
  );

  // unmapped and write-only offsets read as zero
  always_comb
  begin
    rd_data = '0;
    if (wb_adr_i == sw_pos_pkg::OFS_WIRING)
      rd_data[1:0] = wiring;
    else if (wb_adr_i == sw_pos_pkg::OFS_T_CLOSE)
      rd_data = 32'(t_close);
    else if (wb_adr_i == sw_pos_pkg::OFS_T_OPEN)
      rd_data = 32'(t_open);
    else if (wb_adr_i == sw_pos_pkg::OFS_T_SETTLE)
      rd_data = 32'(t_settle);
    else if (wb_adr_i == sw_pos_pkg::OFS_STATUS)
    begin
      rd_data[sw_pos_pkg::ST_CODE_LSB +: 2] = pos_code_o;
      rd_data[sw_pos_pkg::ST_FLAG_LSB +: 4] = {pos_fault_o, pos_transit_o, pos_open_o, pos_closed_o};
      rd_data[sw_pos_pkg::ST_ONE_BIT]       = one_contact_flag_o;
      rd_data[sw_pos_pkg::ST_DRV_CL_BIT]    = drive_close_o;
      rd_data[sw_pos_pkg::ST_DRV_OP_BIT]    = drive_open_o;
    end
    else if (wb_adr_i == sw_pos_pkg::OFS_IRQ_STAT)
      rd_data[sw_pos_pkg::EV_W-1:0] = irq_stat;
    else if (wb_adr_i == sw_pos_pkg::OFS_IRQ_MASK)
      rd_data[sw_pos_pkg::EV_W-1:0] = irq_mask;
  end

  // every access answered one cycle after it is seen
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_acc ? rd_data : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  logic [TIME_W-1:0] drv_len; // consecutive close drive cycles

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !drive_close_o)
      drv_len <= '0;
    else
      drv_len <= drv_len + TIME_W'(1);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_close_taken;
    state == sw_pos_pkg::ST_IDLE && cmd_close && !cmd_open && wired_cl;
  endsequence

  sequence s_close_expired;
    state == sw_pos_pkg::ST_CLOSING && sup && tif.expired && !at_closed && t_settle == '0;
  endsequence

  sequence s_open_expired;
    state == sw_pos_pkg::ST_OPENING && sup && tif.expired && !at_open && t_settle == '0;
  endsequence

  a_flags_one_hot: assert property (
    $onehot({pos_closed_o, pos_open_o, pos_transit_o, pos_fault_o})
    && (pos_closed_o == (pos_code_o == sw_pos_pkg::POS_CLOSED)))
    else $error("position flags not one-hot or off the code");

  a_drive_bound: assert property (
    drive_close_o |-> drv_len < t_close)
    else $error("close drive outlasted its travel time");

  a_drive_cut: assert property (
    state == sw_pos_pkg::ST_CLOSING && at_closed |=> !drive_close_o)
    else $error("close drive not cut at arrival");

  a_drive_timer: assert property (
    (state == sw_pos_pkg::ST_CLOSING || state == sw_pos_pkg::ST_OPENING) |-> tif.busy)
    else $error("drive state outlived its travel timer");

  a_close_transit: assert property (
    s_close_taken ##1 !at_closed |=> pos_transit_o && drive_close_o)
    else $error("close travel not shown in transit");

  a_close_fault: assert property (
    s_close_expired |=> ##1 pos_fault_o)
    else $error("close expiry did not raise fault");

  a_open_fault: assert property (
    s_open_expired |=> ##1 pos_fault_o)
    else $error("open expiry did not raise fault");

  a_two_wire_end: assert property (
    both && state == sw_pos_pkg::ST_IDLE && !hold && aux_closed_i != aux_open_i
    |=> pos_code_o == ($past(aux_closed_i) ? sw_pos_pkg::POS_CLOSED : sw_pos_pkg::POS_OPEN))
    else $error("two-contact end position misreported");

  a_two_wire_bad: assert property (
    both && state == sw_pos_pkg::ST_IDLE && aux_closed_i == aux_open_i |=> pos_fault_o)
    else $error("equal contacts at rest not disturbed");

  a_no_wire: assert property (
    wiring == 2'h0 |=> pos_code_o == sw_pos_pkg::POS_FAULT)
    else $error("unwired contact not forced to disturbed");

  a_one_flag: assert property (
    one_wire |=> one_contact_flag_o)
    else $error("single contact flag missing");

  a_unsupervised: assert property (
    (state == sw_pos_pkg::ST_CLOSING || state == sw_pos_pkg::ST_OPENING) && !sup |=> !pos_transit_o)
    else $error("unsupervised direction shown in transit");

  a_settle_transit: assert property (
    state == sw_pos_pkg::ST_SETTLE |=> pos_transit_o)
    else $error("settle not shown in transit");

endmodule : sw_pos_supervisor

// ==== dv/sw_contacts_model.sv ====
`timescale 1ns/1ps
// switchgear mechanism: contacts follow the coils after a travel delay
module sw_contacts_model (
  // clock
  input  wire logic       clk_i,
  // coils and behaviour
  input  wire logic       drive_close_i,
  input  wire logic       drive_open_i,
  input  wire logic [7:0] delay_i,
  input  wire logic       stuck_i,
  // contacts
  output logic            aux_closed_o,
  output logic            aux_open_o
);
  logic       pos = 1'b0;  // 1 closed, starts open
  logic [7:0] cnt = 8'h00; // travel progress
  // travel only while the coil toward the other end is driven
  always @(posedge clk_i)
  begin
    if (!stuck_i && ((drive_close_i && !pos) || (drive_open_i && pos)))
    begin
      if (cnt == delay_i)
      begin
        pos <= !pos;
        cnt <= 8'h00;
      end
      else
        cnt <= cnt + 8'h01;
    end
    else
      cnt <= 8'h00;
  end
  // both contacts wired
  // mid travel both contacts are open, a stuck mechanism stays put
  assign aux_closed_o = pos && cnt == 8'h00;
  assign aux_open_o   = !pos && cnt == 8'h00;
endmodule : sw_contacts_model

// ==== dv/switchgear_position_supervisor_test.sv ====
`timescale 1ns/1ps
module switchgear_position_supervisor_test;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 0, dly = 0;
  logic [3:0]  sel = 0;
  logic [31:0] dat = 0, q, rnd = 32'h0000_de1c;
  logic [31:0] dat_o;
  logic ack, ac, ao, dc, dop, stk = 0, one, irq;
  logic [1:0] code;
  logic [3:0] fl;
  int n_errors = 0, check_count = 0;
  always #2 clk_i = ~clk_i;
  sw_pos_supervisor sw_pos_supervisor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .aux_closed_i(ac),
    .aux_open_i(ao), .drive_close_o(dc), .drive_open_o(dop), .pos_code_o(code),
    .pos_closed_o(fl[0]), .pos_open_o(fl[1]), .pos_transit_o(fl[2]),
    .pos_fault_o(fl[3]), .one_contact_flag_o(one), .irq_o(irq));
  sw_contacts_model sw_contacts_model_inst (.clk_i(clk_i), .drive_close_i(dc),
    .drive_open_i(dop), .delay_i(dly), .stuck_i(stk), .aux_closed_o(ac), .aux_open_o(ao));
  // galois-free shift register for repeatable stimulus
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // one-hot flags expected for a code
  function logic [3:0] flags(input logic [1:0] c);
    return (c == 2'h2) ? 4'h1 : (c == 2'h1) ? 4'h2 : (c == 2'h0) ? 4'h4 : 4'h8;
  endfunction : flags
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (e !== s)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask : chk
  // classic single wishbone cycle, waits for ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
    if (n >= 50) chk("ack", 1, 0);
  endtask : wb
  // command one travel, measure the coil, then check the resting code
  task mv(input logic [1:0] c, input logic [7:0] d, input logic s, input logic [1:0] ex);
    int n;
    dly <= d; stk <= s;
    wb(1, sw_pos_pkg::OFS_CMD, {30'h0, c});
    n = 0;
    repeat (60)
    begin
      @(posedge clk_i);
      n += int'(dc | dop);
    end
    chk("drive_len", 1, n > 0 && n <= 10);
    chk("code", ex, code);
    chk("flags", flags(ex), fl);
  endtask : mv
  task results;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  initial
  begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    // reset values of the configuration registers other than the settle time
    wb(0, sw_pos_pkg::OFS_T_CLOSE, 0); chk("t_close", sw_pos_pkg::T_CLOSE_RST, q);
    wb(0, sw_pos_pkg::OFS_T_OPEN, 0); chk("t_open", sw_pos_pkg::T_OPEN_RST, q);
    wb(0, sw_pos_pkg::OFS_WIRING, 0); chk("wiring", 3, q);
    wb(0, sw_pos_pkg::OFS_IRQ_MASK, 0); chk("mask", 0, q);
    wb(0, 8'h40, 0); chk("unmapped", 0, q);
    chk("rest_open", sw_pos_pkg::POS_OPEN, code);
    chk("two_flag", 0, one);
    wb(1, sw_pos_pkg::OFS_T_CLOSE, 10);
    wb(1, sw_pos_pkg::OFS_T_OPEN, 10);
    wb(1, sw_pos_pkg::OFS_IRQ_MASK, 7);
    wb(0, sw_pos_pkg::OFS_IRQ_STAT, 0);
    // close with timely feedback raises the closed event
    mv(2'h1, 8'h3, 0, sw_pos_pkg::POS_CLOSED);
    chk("irq", 1, irq);
    wb(0, sw_pos_pkg::OFS_STATUS, 0); chk("status", 32'h0000_0006, q);
    wb(0, sw_pos_pkg::OFS_IRQ_STAT, 0); chk("ev_closed", 1, q[0]);
    repeat (2) @(posedge clk_i);
    chk("irq_clr", 0, irq);
    // stuck mechanism: coil held the full travel time, then fault
    mv(2'h2, 8'h3, 1, sw_pos_pkg::POS_FAULT);
    wb(0, sw_pos_pkg::OFS_IRQ_STAT, 0); chk("ev_fault", 1, q[2]);
    mv(2'h2, 8'h2, 0, sw_pos_pkg::POS_OPEN);
    // random travel times below the limit
    repeat (6)
    begin
      rnd = lfsr(rnd);
      mv(2'h1, {5'h0, rnd[2:0]}, 0, sw_pos_pkg::POS_CLOSED);
      mv(2'h2, {5'h0, rnd[5:3]}, 0, sw_pos_pkg::POS_OPEN);
    end
    // stuck close: fault is held, then the same travel with a settle delay
    mv(2'h1, 8'h3, 1, sw_pos_pkg::POS_FAULT);
    wb(1, sw_pos_pkg::OFS_T_SETTLE, 5);
    mv(2'h1, 8'h3, 1, sw_pos_pkg::POS_OPEN);
    wb(1, sw_pos_pkg::OFS_T_SETTLE, 0);
    // one contact wired
    wb(1, sw_pos_pkg::OFS_WIRING, 1);
    repeat (3) @(posedge clk_i);
    chk("one_flag", 1, one);
    mv(2'h1, 8'h4, 0, sw_pos_pkg::POS_CLOSED);
    // open is unsupervised with only the closed contact: no fault shown
    mv(2'h2, 8'h4, 1, sw_pos_pkg::POS_CLOSED);
    wb(1, sw_pos_pkg::OFS_WIRING, 0);
    repeat (3) @(posedge clk_i);
    chk("unwired", sw_pos_pkg::POS_FAULT, code);
    results();
  end
endmodule : switchgear_position_supervisor_test
